/* core/tmra_cfg.svh */
// constants of the 8-bit interval/pwm/capture timer
// assumes inclusion by bare name from core/
`ifndef TMRA_CFG_SVH
`define TMRA_CFG_SVH
`define TMRA_CTRL_ADDR     8'hE2
`define TMRA_CTRL_RESET    8'h00
`define TMRA_MODE_HI       7
`define TMRA_MODE_LO       6
`define TMRA_CLK_HI        5
`define TMRA_CLK_LO        3
`define TMRA_CLR_BIT       2
`define TMRA_MIE_BIT       1
`define TMRA_OIE_BIT       0
`define TMRA_PND_OVF_BIT   0
`define TMRA_PND_MATCH_BIT 1
`define TMRA_VEC_OVF       8'hD0
`define TMRA_VEC_MATCH     8'hCE
`define TMRA_DIV_W         10
`define TMRA_MASK_1024     10'h3FF
`define TMRA_MASK_256      10'h0FF
`define TMRA_MASK_64       10'h03F
`define TMRA_MASK_8        10'h007
`define TMRA_CLR_MASK      (8'h01 << `TMRA_CLR_BIT)
`endif

/* core/tmra_pkg.sv */
// types of the 8-bit interval/pwm/capture timer
// assumes nothing of its surroundings
package tmra_pkg;
    typedef enum logic [1:0] {
        TMRA_INTERVAL = 2'h0,
        TMRA_CAPTURE  = 2'h1,
        TMRA_PWM      = 2'h3,
        TMRA_RSVD     = 2'h2
    } tmra_mode_t;
    typedef enum logic [2:0] {
        TMRA_DIV1024 = 3'h0,
        TMRA_DIV256  = 3'h1,
        TMRA_DIV64   = 3'h2,
        TMRA_DIV8    = 3'h3,
        TMRA_DIV1    = 3'h4,
        TMRA_EXTCLK  = 3'h5
    } tmra_clk_t;
endpackage

/* core/tmra_timer.sv */
// 8-bit timer: interval toggle, edge capture and pwm modes
// assumes a cpu register port on sys_clk_in; pins synchronous to the clock
//
// Functional notes
// [R1] mode field of control register picks interval, capture or pwm
// [R2] tick source: clock divided by 1024,256,64,8,1 or external clock pin
// [R3] datapath is 8-bit up-counter, equality comparator, software reference register
// [R4] overflow and match/capture requests on level zero, vectors D0H and CEH
// [R5] reset makes control 00H: interval, divide by 1024, interrupts off
// [R6] writing one to the clear bit zeroes the counter at once
// [R7] match/capture request only while control bit 1 is set
// [R8] pending bit 1 set on match or capture, cleared by writing zero
// [R9] pending bit 0 marks overflow, cleared on service or by zero write
// [R10] interval match requests interrupt and resets counter, counting resumes
// [R11] interval toggle output inverts on every match
// [R12] pwm match leaves counter running, wrapping FFH to 00H
// [R13] pwm output low while reference <= counter, else high
// [R14] pwm period is 256 ticks of the selected clock
// [R15] capture edge selectable rising or falling
// [R16] on selected capture edge counter copies into reference register
// [R17] capture mode requests overflow and capture interrupts
// [R18] counter steps once per tick; every wrap sets overflow pending except an interval match at FFH
`timescale 1ns/1ns
`include "tmra_cfg.svh"
module tmra_timer #(
    parameter int CNT_W = 8
) (
    // clock, reset, enable
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             clk_en_in,
    // register port
    input  wire logic [7:0]       reg_addr_in,
    input  wire logic             reg_wr_in,
    input  wire logic [7:0]       reg_wdata_in,
    input  wire logic             data_wr_in,
    input  wire logic [7:0]       data_wdata_in,
    input  wire logic             pnd_wr_in,
    input  wire logic [1:0]       pnd_wdata_in,
    input  wire logic             ovf_serviced_in,
    input  wire logic             capture_rising_in,
    // pins
    input  wire logic             external_clock_input_in,
    input  wire logic             capture_input_pin_in,
    output logic                  interval_toggle_output_out,
    output logic                  pwm_output_pin_out,
    // cpu side
    output logic [7:0]            timer_control_out,
    output logic [CNT_W-1:0]      reference_data_register_out,
    output logic [CNT_W-1:0]      up_counter_out,
    output logic [1:0]            interrupt_pending_register_out,
    output logic                  interrupt_level_zero_out,
    output logic [7:0]            irq_vector_out
);
    initial begin
        if (CNT_W != 8) $error("counter must be 8 bits");
    end

    logic [7:0]              timer_control;
    logic [CNT_W-1:0]        up_counter;
    logic [CNT_W-1:0]        reference_data_register;
    logic [1:0]              pnd;
    logic [`TMRA_DIV_W-1:0]  div;
    logic                    ext_d;
    logic                    cap_d;
    logic                    tog;
    logic                    pwm;
    logic                    irq;
    logic [7:0]              vec;

    wire                     ctrl_wr = clk_en_in && reg_wr_in && reg_addr_in == `TMRA_CTRL_ADDR;
    wire tmra_pkg::tmra_mode_t mode = tmra_pkg::tmra_mode_t'(timer_control[`TMRA_MODE_HI:`TMRA_MODE_LO]); // [R1]
    wire tmra_pkg::tmra_clk_t  csel = tmra_pkg::tmra_clk_t'(timer_control[`TMRA_CLK_HI:`TMRA_CLK_LO]);
    wire                     mie = timer_control[`TMRA_MIE_BIT];
    wire                     oie = timer_control[`TMRA_OIE_BIT];
    wire [`TMRA_DIV_W-1:0]   next_div = div + 10'h001;

    function automatic logic div_tick(input logic [`TMRA_DIV_W-1:0] d, input logic [`TMRA_DIV_W-1:0] m);
        div_tick = (d & m) == m;
    endfunction

    // clock select and tick
    logic tick;
    always_comb
    begin
        unique case (csel) // [R2]
            tmra_pkg::TMRA_DIV1024: tick = div_tick(div, `TMRA_MASK_1024);
            tmra_pkg::TMRA_DIV256:  tick = div_tick(div, `TMRA_MASK_256);
            tmra_pkg::TMRA_DIV64:   tick = div_tick(div, `TMRA_MASK_64);
            tmra_pkg::TMRA_DIV8:    tick = div_tick(div, `TMRA_MASK_8);
            tmra_pkg::TMRA_DIV1:    tick = 1'b1;
            tmra_pkg::TMRA_EXTCLK:  tick = external_clock_input_in && !ext_d;
            default:                tick = 1'b0;
        endcase
    end

    // counter, pending and request next values
    wire                     match    = up_counter == reference_data_register; // [R3]
    wire                     wrap     = tick && up_counter == 8'hFF;
    wire                     cap_edge = capture_rising_in ? (capture_input_pin_in && !cap_d)
                                                          : (!capture_input_pin_in && cap_d); // [R15]
    wire                     is_int   = mode == tmra_pkg::TMRA_INTERVAL;
    wire                     is_cap   = mode == tmra_pkg::TMRA_CAPTURE;
    wire                     is_pwm   = mode == tmra_pkg::TMRA_PWM;
    wire                     int_hit  = is_int && tick && match;
    wire                     cap_hit  = is_cap && cap_edge;
    wire                     pwm_hit  = is_pwm && tick && match;
    wire                     m_ev     = int_hit || cap_hit || pwm_hit; // [R8] [R17]
    wire                     clr_now  = ctrl_wr && reg_wdata_in[`TMRA_CLR_BIT];
    wire [CNT_W-1:0]         next_up_counter = clr_now ? 8'h00 :                      // [R6]
                                               int_hit ? 8'h00 :                      // [R10]
                                               tick    ? up_counter + 8'h01 :         // [R12] [R18]
                                               up_counter;
    wire                     ovf_clr  = (pnd_wr_in && !pnd_wdata_in[`TMRA_PND_OVF_BIT]) || ovf_serviced_in;
    wire                     mat_clr  = pnd_wr_in && !pnd_wdata_in[`TMRA_PND_MATCH_BIT];
    wire                     ovf_set  = wrap && !int_hit;
    wire [1:0]               next_pnd = {m_ev || (pnd[1] && !mat_clr),             // [R8]
                                         ovf_set || (pnd[0] && !ovf_clr)};         // [R9] [R18]
    wire                     next_irq = (next_pnd[1] && mie) || (next_pnd[0] && oie); // [R4] [R7]
    wire [7:0]               next_vec = (next_pnd[1] && mie) ? `TMRA_VEC_MATCH : `TMRA_VEC_OVF;

    // state update
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            timer_control           <= `TMRA_CTRL_RESET; // [R5]
            up_counter              <= 8'h00;
            reference_data_register <= 8'h00;
            pnd                     <= 2'h0;
            div                     <= 10'h000;
            ext_d                   <= 1'b0;
            cap_d                   <= 1'b0;
            tog                     <= 1'b0;
            pwm                     <= 1'b0;
            irq                     <= 1'b0;
            vec                     <= `TMRA_VEC_OVF;
        end
        else if (clk_en_in)
        begin
            if (ctrl_wr)
                timer_control <= reg_wdata_in & ~`TMRA_CLR_MASK;
            if (cap_hit)
                reference_data_register <= up_counter; // [R16]
            else if (data_wr_in)
                reference_data_register <= data_wdata_in;
            up_counter <= next_up_counter;
            pnd        <= next_pnd;
            div        <= next_div;
            ext_d      <= external_clock_input_in;
            cap_d      <= capture_input_pin_in;
            if (int_hit)
                tog <= !tog; // [R11]
            pwm        <= reference_data_register > next_up_counter; // [R13] [R14]
            irq        <= next_irq;
            vec        <= next_vec;
        end
    end

    // outputs
    assign interval_toggle_output_out     = tog;
    assign pwm_output_pin_out             = pwm;
    assign timer_control_out              = timer_control;
    assign reference_data_register_out    = reference_data_register;
    assign up_counter_out                 = up_counter;
    assign interrupt_pending_register_out = pnd;
    assign interrupt_level_zero_out       = irq;
    assign irq_vector_out                 = vec;

    // checks
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    reset_ctrl_a:     assert property ($past(rst_in) |-> timer_control == 8'h00) // [R5]
        else $error("control not 00 after reset");
    clear_now_a:      assert property (clr_now |=> up_counter == 8'h00) // [R6]
        else $error("counter not cleared");
    int_gate_a:       assert property (!mie && !oie |=> !irq) // [R7]
        else $error("interrupt without enable");
    match_sticky_a:   assert property (pnd[1] && !mat_clr && clk_en_in |=> pnd[1]) // [R8]
        else $error("match pending lost");
    match_set_a:      assert property (m_ev && clk_en_in |=> pnd[1]) // [R8]
        else $error("match pending not set");
    ovf_set_a:        assert property (ovf_set && clk_en_in |=> pnd[0]) // [R9]
        else $error("overflow pending not set");
    interval_clr_a:   assert property (int_hit && !clr_now && clk_en_in |=> up_counter == 8'h00) // [R10]
        else $error("interval match did not clear counter");
    toggle_a:         assert property (int_hit && clk_en_in |=> tog != $past(tog)) // [R11]
        else $error("toggle output not inverted");
    pwm_wrap_a:       assert property (is_pwm && tick && clk_en_in && !clr_now && up_counter == 8'hFF
                                       |=> up_counter == 8'h00) // [R12]
        else $error("pwm counter did not wrap");
    pwm_level_a:      assert property (clk_en_in |=> pwm == ($past(reference_data_register) > up_counter)) // [R13]
        else $error("pwm level wrong");
    capture_a:        assert property (cap_hit && clk_en_in |=> reference_data_register == $past(up_counter)) // [R16]
        else $error("capture value wrong");
    pwm_run_a:        assert property (pwm_hit && !clr_now && clk_en_in |=> up_counter == $past(up_counter) + 8'h01) // [R12]
        else $error("pwm match disturbed counter");
    count_step_a:     assert property (tick && !clr_now && !int_hit && clk_en_in |=> up_counter == $past(up_counter) + 8'h01) // [R18]
        else $error("counter did not step");
    ovf_clear_a:      assert property (ovf_serviced_in && !ovf_set && clk_en_in |=> !pnd[0]) // [R9]
        else $error("overflow pending not cleared");
    match_clear_a:    assert property (mat_clr && !m_ev && clk_en_in |=> !pnd[1]) // [R8]
        else $error("match pending not cleared");
    irq_level_a:      assert property (clk_en_in |=> irq == ((pnd[1] && $past(mie)) || (pnd[0] && $past(oie)))) // [R4]
        else $error("interrupt level wrong");
    vec_sel_a:        assert property (clk_en_in |=> vec == ((pnd[1] && $past(mie)) ? `TMRA_VEC_MATCH : `TMRA_VEC_OVF)) // [R4]
        else $error("interrupt vector wrong");
    toggle_hold_a:    assert property (!int_hit && clk_en_in |=> tog == $past(tog)) // [R11]
        else $error("toggle output moved without match");
    div_run_a:        assert property (clk_en_in |=> div == $past(div) + 10'h001) // [R2]
        else $error("divider not running");
    ref_hold_a:       assert property (!is_cap && !data_wr_in && clk_en_in |=> $stable(reference_data_register)) // [R16]
        else $error("reference changed without write");
    freeze_a:         assert property (!clk_en_in |=> $stable(up_counter) && $stable(pnd)) // [R18]
        else $error("state moved while disabled");
    cv_interval:      cover property (int_hit && tog);
    cv_capture:       cover property (cap_hit && clk_en_in);
    cv_capture_fall:  cover property (cap_hit && !capture_rising_in);
    cv_pwm_wrap:      cover property (is_pwm && wrap);
    cv_both_pending:  cover property (pnd == 2'h3);
endmodule

/* test/tmra_src.sv */
// far-side model: external tick source and capture signal source
// assumes the bench calls its tasks; pins change on falling edges only
`timescale 1ns/1ns
module tmra_src (
    // clock
    input  wire logic sys_clk_in,
    // pins
    output logic      ext_clk_out,
    output logic      cap_out
);
    initial ext_clk_out = 1'b0;
    initial cap_out = 1'b0;
    // one external tick, clock stands low outside it
    task automatic tick();
        @(negedge sys_clk_in) ext_clk_out = 1'b1;
        repeat (4) @(negedge sys_clk_in);
        ext_clk_out = 1'b0;
        repeat (4) @(negedge sys_clk_in);
    endtask
    task automatic set_cap(input logic v);
        @(negedge sys_clk_in) cap_out = v;
        repeat (6) @(negedge sys_clk_in);
    endtask
endmodule

/* test/tmra_timer_bench.sv */
// self-checking bench of the 8-bit interval/pwm/capture timer
// assumes core/ on the include path and tmra_src compiled first
`timescale 1ns/1ns
module tmra_timer_bench;
    logic       sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, data_wr = 1'b0;
    logic       pnd_wr = 1'b0, ovf_srv = 1'b0, cap_rise = 1'b1, ext_clk, cap_pin, tgl, pwm, irq;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, data_wdata = 8'h00, ctrl, refd, cnt, vec;
    logic [1:0] pnd_wdata = 2'h3, pnd;
    int         err_count = 0, num_checks = 0;
    always #2 sys_clk = ~sys_clk;
    tmra_src tmra_src_i (.sys_clk_in(sys_clk), .ext_clk_out(ext_clk), .cap_out(cap_pin));
    tmra_timer tmra_timer_i (.sys_clk_in(sys_clk), .rst_in(rst), .clk_en_in(clk_en),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .data_wr_in(data_wr),
        .data_wdata_in(data_wdata), .pnd_wr_in(pnd_wr), .pnd_wdata_in(pnd_wdata),
        .ovf_serviced_in(ovf_srv), .capture_rising_in(cap_rise), .external_clock_input_in(ext_clk),
        .capture_input_pin_in(cap_pin), .interval_toggle_output_out(tgl), .pwm_output_pin_out(pwm),
        .timer_control_out(ctrl), .reference_data_register_out(refd), .up_counter_out(cnt),
        .interrupt_pending_register_out(pnd), .interrupt_level_zero_out(irq), .irq_vector_out(vec));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one-cycle strobes: 0 control, 1 reference, 2 pending, 3 overflow serviced
    task automatic strobe(input int kind, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        data_wdata = d;
        pnd_wdata = d[1:0];
        {ovf_srv, pnd_wr, data_wr, reg_wr} = 4'h1 << kind;
        @(negedge sys_clk) {ovf_srv, pnd_wr, data_wr, reg_wr} = 4'h0;
    endtask
    // what: 0 counter equals v, 1 overflow pending, 2 match pending
    task automatic wait_until(input int what, input logic [7:0] v);
        int n;
        n = 0;
        while (!((what == 0) ? cnt === v : pnd[what-1] === 1'b1) && n < 600)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 600) err_count++;
    endtask
    task automatic t_interval();
        strobe(1, 8'h00, 8'h05);
        strobe(0, 8'hE2, 8'h26);
        check(cnt, 8'h00);
        check(ctrl, 8'h22);
        wait_until(2, 8'h00);
        check(cnt, 8'h00);
        check({tgl, irq, pnd}, 8'h0E);
        check(vec, `TMRA_VEC_MATCH);
        strobe(2, 8'h00, 8'h01);
        check(pnd, 2'h0);
        wait_until(2, 8'h00);
        check(tgl, 1'b0);
        strobe(0, 8'hE2, 8'h20);
        strobe(2, 8'h00, 8'h00);
        wait_until(2, 8'h00);
        check({irq, vec}, {1'b0, `TMRA_VEC_OVF});
        strobe(0, 8'hE3, 8'hFF);
        check(ctrl, 8'h20);
        $display("test interval done");
    endtask
    task automatic t_pwm();
        strobe(2, 8'h00, 8'h00);
        strobe(1, 8'h00, 8'h80);
        strobe(0, 8'hE2, 8'hE5);
        wait_until(0, 8'h40);
        check(pwm, 1'b1);
        wait_until(0, 8'h90);
        check(pwm, 1'b0);
        wait_until(1, 8'h00);
        check({cnt, irq}, 9'h001);
        check(vec, `TMRA_VEC_OVF);
        strobe(3, 8'h00, 8'h00);
        check(pnd[0], 1'b0);
        $display("test pwm done");
    endtask
    task automatic t_capture();
        strobe(2, 8'h00, 8'h00);
        strobe(0, 8'hE2, 8'h6E);
        repeat (3) tmra_src_i.tick();
        check(cnt, 8'h03);
        tmra_src_i.set_cap(1'b1);
        check({refd, pnd[1]}, 9'h007);
        strobe(2, 8'h00, 8'h00);
        cap_rise = 1'b0;
        tmra_src_i.tick();
        tmra_src_i.set_cap(1'b0);
        check(refd, 8'h04);
        tmra_src_i.tick();
        tmra_src_i.set_cap(1'b1);
        check(refd, 8'h04);
        clk_en = 1'b0;
        tmra_src_i.tick();
        clk_en = 1'b1;
        check(cnt, 8'h05);
        $display("test capture done");
    endtask
    initial
    begin
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        check(ctrl, `TMRA_CTRL_RESET);
        check(cnt, 8'h00);
        check(pnd, 2'h0);
        check(vec, `TMRA_VEC_OVF);
        $display("test reset done");
        t_interval();
        t_pwm();
        t_capture();
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_count++;
        test_done();
    end
endmodule
